// ===== core_status.sv
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
// Contract
// [R1] Instruction pointer 32 bits, low two bits zero.
// [R2] Masked overflow sets arithmetic bit 8 flag.
// [R3] Unmasked overflow raises fault, flag untouched.
// [R4] Arithmetic bit 12 masks overflow fault.
// [R5] Arithmetic bit 15 selects precise-only faults.
// [R6] Unmaskable interrupt always taken, above priority 31.
// [R7] Interrupt not above current priority is pended.
// [R8] Process bits 16-20 hold task priority.
// [R9] Priorities run 0 to 31, 31 highest.
// [R10] Process bit 10: zero program, one interrupt.
// [R11] Accepted vector indexes table, then implicit call.
// [R12] Destination marked busy; free instructions issue.
// [R13] Call type in frame link low three bits.
// [R14] Call writes next instruction address to return local.
// [R15] Frames 64-byte aligned, first 64 bytes locals.
// [R16] Previous frame address in frame link bits 4-31.
// [R17] Stack top local holds frame's last byte.
// [R18] Stack grows upward, contiguous frames.
// [R19] Each call saves caller locals, fresh set.
// [R20] Higher interrupt: service, load priority, set state.
module core_status import core_status_pkg::*; (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // AXI4-Lite write address and data.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response.
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read.
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Execution events.
  input wire logic ip_load,
  input wire logic [31:0] ip_value,
  input wire logic overflow_event,
  output logic overflow_fault,
  output logic precise_fault_only_bit,
  // Interrupt requests.
  input wire logic nmi_req,
  input wire irq_req_t irq_in,
  input wire logic int_return,
  output logic int_accept,
  output logic [31:0] handler_addr,
  output logic pend_write,
  output logic [4:0] pend_priority,
  output logic [7:0] pend_vector,
  output logic state_flag,
  output logic [4:0] cur_priority,
  // Register scoreboard.
  input wire logic issue_req,
  input wire logic [3:0] issue_dest,
  input wire logic [3:0] issue_src_a,
  input wire logic [3:0] issue_src_b,
  input wire logic retire_valid,
  input wire logic [3:0] retire_dest,
  output logic issue_grant,
  output logic [15:0] busy,
  // Procedure calls and returns.
  input wire logic call_req,
  input wire logic [2:0] call_type,
  input wire logic [31:0] call_next_ip,
  input wire logic ret_req,
  output logic save_locals,
  output logic [31:0] save_addr,
  output logic ret_valid,
  output logic [2:0] ret_type,
  output logic [31:0] ret_ip,
  // Architectural words.
  output logic [31:0] instruction_pointer,
  output logic [31:0] arith_controls,
  output logic [31:0] process_controls,
  output logic [31:0] frame_link_local,
  output logic [31:0] stack_top_local,
  output logic [31:0] return_address_local
);

  core_state_t s_q;
  core_state_t s_d;
  logic take;
  logic defer;
  logic [4:0] new_prio;
  logic [7:0] new_vec;

  int_arbiter u_arb (
    .nmi(nmi_req),
    .irq(irq_in),
    .cur_priority(s_q.process[PRIO_MSB:PRIO_LSB]),  // see [R8]
    .take(take),
    .defer(defer),
    .new_priority(new_prio),
    .new_vector(new_vec)
  );

  function automatic logic known_reg(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    unique case ({a[7:2], 2'b00})
      OFS_IP, OFS_ARITH, OFS_PROCESS, OFS_PENDING, OFS_FRAME_LINK,
      OFS_STACK_TOP, OFS_RETURN_ADDR, OFS_TABLE_BASE, OFS_FRAME_PTR,
      OFS_BUSY: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Starts a new frame above the current top and links it to the caller.
  function automatic core_state_t open_frame(input core_state_t s,
                                             input logic [2:0] kind,
                                             input logic [31:0] ret_addr);
    logic [31:0] nfp;
    nfp = (s.stack_top + FRAME_BYTES) & FRAME_MASK;  // see [R15] [R18]
    s.save_locals = 1'b1;  // see [R19]
    s.save_addr = s.frame_ptr & FRAME_MASK;
    s.frame_link = {s.frame_ptr[31:LINK_LSB], 1'b0, kind};  // see [R13] [R16]
    s.return_addr = ret_addr & IP_MASK;  // see [R14]
    s.stack_top = nfp + FRAME_LAST;  // see [R17]
    s.frame_ptr = nfp;
    return s;
  endfunction

  always_comb begin
    logic [7:0] widx;
    logic [31:0] wv;
    logic [15:0] need;
    widx = 8'h00;
    wv = 32'h0000_0000;
    need = 16'h0000;
    s_d = s_q;
    s_d.ovf_fault = 1'b0;
    s_d.int_accept = 1'b0;
    s_d.pend_write = 1'b0;
    s_d.save_locals = 1'b0;
    s_d.issue_grant = 1'b0;
    s_d.ret_valid = 1'b0;

    // Bus: address and data are captured in either order.
    if (s_axi_awvalid && s_q.bus.aw_rdy) begin
      s_d.bus.aw_held = 1'b1;
      s_d.bus.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.bus.w_rdy) begin
      s_d.bus.w_held = 1'b1;
      s_d.bus.w_data = s_axi_wdata;
      s_d.bus.w_strb = s_axi_wstrb;
    end
    if (s_q.bus.bvalid && s_axi_bready) begin
      s_d.bus.bvalid = 1'b0;
    end
    if (s_d.bus.aw_held && s_d.bus.w_held && !s_d.bus.bvalid) begin
      widx = {s_d.bus.aw_addr[7:2], 2'b00};
      s_d.bus.aw_held = 1'b0;
      s_d.bus.w_held = 1'b0;
      s_d.bus.bvalid = 1'b1;
      s_d.bus.bresp = known_reg(widx) ? RESP_OKAY : RESP_SLVERR;
      unique case (widx)
        OFS_IP: begin
          wv = merge_strb(s_q.ip, s_d.bus.w_data, s_d.bus.w_strb);
          s_d.ip = wv & IP_MASK;
        end
        OFS_ARITH: begin
          wv = merge_strb(s_q.arith, s_d.bus.w_data, s_d.bus.w_strb);
          s_d.arith = wv & ARITH_WMASK;
        end
        OFS_PROCESS: begin
          wv = merge_strb(s_q.process, s_d.bus.w_data, s_d.bus.w_strb);
          s_d.process = (wv & PROCESS_WMASK) | (s_q.process & ~PROCESS_WMASK);
        end
        OFS_PENDING: begin
          if (s_d.bus.w_strb[0] && s_d.bus.w_data[0]) begin
            s_d.pend.valid = 1'b0;
          end
        end
        OFS_FRAME_LINK: begin
          s_d.frame_link =
            merge_strb(s_q.frame_link, s_d.bus.w_data, s_d.bus.w_strb);
        end
        OFS_STACK_TOP: begin
          s_d.stack_top =
            merge_strb(s_q.stack_top, s_d.bus.w_data, s_d.bus.w_strb);
        end
        OFS_RETURN_ADDR: begin
          wv = merge_strb(s_q.return_addr, s_d.bus.w_data, s_d.bus.w_strb);
          s_d.return_addr = wv & IP_MASK;
        end
        OFS_TABLE_BASE: begin
          s_d.table_base =
            merge_strb(s_q.table_base, s_d.bus.w_data, s_d.bus.w_strb);
        end
        OFS_FRAME_PTR: begin
          wv = merge_strb(s_q.frame_ptr, s_d.bus.w_data, s_d.bus.w_strb);
          s_d.frame_ptr = wv & FRAME_MASK;  // see [R15]
        end
        default: begin
        end
      endcase
    end

    // Bus: reads answer one cycle after the address is taken.
    if (s_q.bus.rvalid && s_axi_rready) begin
      s_d.bus.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.bus.ar_rdy) begin
      s_d.bus.rvalid = 1'b1;
      s_d.bus.rresp = known_reg(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case ({s_axi_araddr[7:2], 2'b00})
        OFS_IP: s_d.bus.rdata = s_q.ip;
        OFS_ARITH: s_d.bus.rdata = s_q.arith;
        OFS_PROCESS: s_d.bus.rdata = s_q.process;
        OFS_PENDING: begin
          s_d.bus.rdata = {16'h0000, s_q.pend.vector, 2'b00,
                           s_q.pend.priority_lvl, s_q.pend.valid};
        end
        OFS_FRAME_LINK: s_d.bus.rdata = s_q.frame_link;
        OFS_STACK_TOP: s_d.bus.rdata = s_q.stack_top;
        OFS_RETURN_ADDR: s_d.bus.rdata = s_q.return_addr;
        OFS_TABLE_BASE: s_d.bus.rdata = s_q.table_base;
        OFS_FRAME_PTR: s_d.bus.rdata = s_q.frame_ptr;
        OFS_BUSY: s_d.bus.rdata = {16'h0000, s_q.busy};
        default: s_d.bus.rdata = 32'h0000_0000;
      endcase
    end

    // Core events come last so they win over a software write.
    if (ip_load) begin
      s_d.ip = ip_value & IP_MASK;  // see [R1]
    end

    if (overflow_event) begin
      if (s_q.arith[OVF_MASK_BIT]) begin  // see [R4]
        s_d.arith[OVF_FLAG_BIT] = 1'b1;  // see [R2]
      end else begin
        s_d.ovf_fault = 1'b1;  // see [R3]
      end
    end

    // Scoreboard: retire first so a freed register may issue at once.
    if (retire_valid) begin
      s_d.busy[retire_dest] = 1'b0;
    end
    need[issue_dest] = 1'b1;
    need[issue_src_a] = 1'b1;
    need[issue_src_b] = 1'b1;
    if (issue_req && ((s_d.busy & need) == 16'h0000)) begin
      s_d.issue_grant = 1'b1;
      s_d.busy[issue_dest] = 1'b1;  // see [R12]
    end

    // Returns report the stored call type; every type restores the caller frame the same way.
    if (ret_req) begin
      s_d.ret_valid = 1'b1;
      s_d.ret_type = s_q.frame_link[2:0];  // see [R13]
      s_d.ret_ip = s_q.return_addr;
      s_d.frame_ptr = {s_q.frame_link[31:LINK_LSB], 4'h0} & FRAME_MASK;
      s_d.stack_top = s_q.frame_ptr - 32'h0000_0001;
    end

    unique case (s_q.mode)
      MODE_PROGRAM: begin
        if (int_return) begin
        end
      end
      MODE_SERVICE: begin
        if (int_return) begin
          s_d.mode = MODE_PROGRAM;
          s_d.process = s_q.saved_process;
        end
      end
    endcase

    if (defer) begin
      s_d.pend_write = 1'b1;  // see [R7]
      s_d.pend.valid = 1'b1;
      s_d.pend.priority_lvl = irq_in.priority_lvl;
      s_d.pend.vector = irq_in.vector;
    end

    if (take) begin
      s_d.int_accept = 1'b1;
      s_d.saved_process = s_q.process;
      s_d.mode = MODE_SERVICE;  // see [R20]
      s_d.process[PRIO_MSB:PRIO_LSB] = new_prio;  // see [R20] [R6]
      s_d.handler_addr =
        s_q.table_base + ({24'h000000, new_vec} << TABLE_STRIDE_SHIFT);
      s_d = open_frame(s_d, CALL_INT, s_q.ip);  // see [R11]
    end else if (call_req && !ret_req) begin
      s_d = open_frame(s_d, call_type, call_next_ip);  // see [R14] [R19]
    end

    s_d.process[STATE_BIT] = (s_d.mode == MODE_SERVICE);  // see [R10]

    s_d.bus.aw_rdy = !s_d.bus.aw_held && !s_d.bus.bvalid;
    s_d.bus.w_rdy = !s_d.bus.w_held && !s_d.bus.bvalid;
    s_d.bus.ar_rdy = !s_d.bus.rvalid;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.mode <= MODE_PROGRAM;
      s_q.ip <= RESET_WORD;
      s_q.arith <= RESET_WORD;
      s_q.process <= RESET_WORD;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.bus.aw_rdy;
  assign s_axi_wready = s_q.bus.w_rdy;
  assign s_axi_bvalid = s_q.bus.bvalid;
  assign s_axi_bresp = s_q.bus.bresp;
  assign s_axi_arready = s_q.bus.ar_rdy;
  assign s_axi_rvalid = s_q.bus.rvalid;
  assign s_axi_rdata = s_q.bus.rdata;
  assign s_axi_rresp = s_q.bus.rresp;
  assign overflow_fault = s_q.ovf_fault;
  assign precise_fault_only_bit = s_q.arith[PRECISE_BIT];  // see [R5]
  assign int_accept = s_q.int_accept;
  assign handler_addr = s_q.handler_addr;
  assign pend_write = s_q.pend_write;
  assign pend_priority = s_q.pend.priority_lvl;
  assign pend_vector = s_q.pend.vector;
  assign state_flag = s_q.process[STATE_BIT];
  assign cur_priority = s_q.process[PRIO_MSB:PRIO_LSB];
  assign issue_grant = s_q.issue_grant;
  assign busy = s_q.busy;
  assign save_locals = s_q.save_locals;
  assign save_addr = s_q.save_addr;
  assign ret_valid = s_q.ret_valid;
  assign ret_type = s_q.ret_type;
  assign ret_ip = s_q.ret_ip;
  assign instruction_pointer = s_q.ip;
  assign arith_controls = s_q.arith;
  assign process_controls = s_q.process;
  assign frame_link_local = s_q.frame_link;
  assign stack_top_local = s_q.stack_top;
  assign return_address_local = s_q.return_addr;

endmodule

// ===== core_status_asserts.sv
`timescale 1ns/100ps
module core_status_asserts import core_status_pkg::*; (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Core events.
  input wire logic ip_load,
  input wire logic [31:0] ip_value,
  input wire logic overflow_event,
  input wire logic overflow_fault,
  input wire logic precise_fault_only_bit,
  input wire logic nmi_req,
  input wire irq_req_t irq_in,
  input wire logic int_accept,
  input wire logic pend_write,
  input wire logic [4:0] pend_priority,
  input wire logic state_flag,
  input wire logic [4:0] cur_priority,
  input wire logic call_req,
  input wire logic [2:0] call_type,
  input wire logic [31:0] call_next_ip,
  input wire logic ret_req,
  input wire logic save_locals,
  input wire logic [31:0] save_addr,
  // Architectural words.
  input wire logic [31:0] instruction_pointer,
  input wire logic [31:0] arith_controls,
  input wire logic [31:0] process_controls,
  input wire logic [31:0] frame_link_local,
  input wire logic [31:0] stack_top_local,
  input wire logic [31:0] return_address_local
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic [4:0] irq_prio = irq_in.priority_lvl;
  wire logic irq_only = irq_in.valid && !nmi_req;
  sequence s_call;
    call_req && !ret_req && !nmi_req && !irq_in.valid;
  endsequence
  sequence s_frame;
    save_locals && stack_top_local[5:0] == 6'h3F &&
      frame_link_local[31:4] == save_addr[31:4] &&
      stack_top_local > save_addr;
  endsequence
  a_ip_align: assert property (
    ip_load |=> instruction_pointer == ($past(ip_value) & IP_MASK))
    else $error("instruction pointer not loaded aligned");
  a_ovf_flag: assert property (
    overflow_event && arith_controls[OVF_MASK_BIT] |=>
      arith_controls[OVF_FLAG_BIT] && !overflow_fault)
    else $error("masked overflow did not set the flag");
  a_ovf_fault: assert property (
    overflow_event && !arith_controls[OVF_MASK_BIT] |=>
      overflow_fault && $stable(arith_controls[OVF_FLAG_BIT]))
    else $error("unmasked overflow handled wrongly");
  a_precise_mirror: assert property (
    precise_fault_only_bit == arith_controls[PRECISE_BIT])
    else $error("precise bit output differs");
  a_state_prio: assert property (
    state_flag == process_controls[STATE_BIT] &&
      cur_priority == process_controls[PRIO_MSB:PRIO_LSB])
    else $error("state or priority output differs");
  a_irq_defer: assert property (
    irq_only && irq_prio <= cur_priority |=>
      pend_write && pend_priority == $past(irq_prio) && !int_accept)
    else $error("low interrupt not pended");
  a_irq_take: assert property (
    irq_only && irq_prio > cur_priority |=> int_accept && state_flag &&
      cur_priority == $past(irq_prio) && frame_link_local[2:0] == CALL_INT)
    else $error("high interrupt not taken");
  a_nmi_take: assert property (
    nmi_req |=> int_accept && state_flag && cur_priority == PRIO_MAX)
    else $error("unmaskable interrupt not taken");
  a_call_frame: assert property (
    s_call |=> s_frame ##0 frame_link_local[2:0] == $past(call_type) &&
      return_address_local == ($past(call_next_ip) & IP_MASK))
    else $error("call frame not built");
endmodule

bind core_status core_status_asserts i_core_status_asserts (
  .core_clk(core_clk), .rst_n(rst_n), .ip_load(ip_load),
  .ip_value(ip_value), .overflow_event(overflow_event),
  .overflow_fault(overflow_fault),
  .precise_fault_only_bit(precise_fault_only_bit), .nmi_req(nmi_req),
  .irq_in(irq_in), .int_accept(int_accept), .pend_write(pend_write),
  .pend_priority(pend_priority), .state_flag(state_flag),
  .cur_priority(cur_priority), .call_req(call_req),
  .call_type(call_type), .call_next_ip(call_next_ip), .ret_req(ret_req),
  .save_locals(save_locals), .save_addr(save_addr),
  .instruction_pointer(instruction_pointer),
  .arith_controls(arith_controls), .process_controls(process_controls),
  .frame_link_local(frame_link_local), .stack_top_local(stack_top_local),
  .return_address_local(return_address_local)
);

// ===== core_status_pkg.sv
package core_status_pkg;

  // Register byte offsets on the register bus.
  localparam logic [7:0] OFS_IP = 8'h00;
  localparam logic [7:0] OFS_ARITH = 8'h04;
  localparam logic [7:0] OFS_PROCESS = 8'h08;
  localparam logic [7:0] OFS_PENDING = 8'h0C;
  localparam logic [7:0] OFS_FRAME_LINK = 8'h10;
  localparam logic [7:0] OFS_STACK_TOP = 8'h14;
  localparam logic [7:0] OFS_RETURN_ADDR = 8'h18;
  localparam logic [7:0] OFS_TABLE_BASE = 8'h1C;
  localparam logic [7:0] OFS_FRAME_PTR = 8'h20;
  localparam logic [7:0] OFS_BUSY = 8'h24;

  // Field positions.
  localparam int OVF_FLAG_BIT = 8;
  localparam int OVF_MASK_BIT = 12;
  localparam int PRECISE_BIT = 15;
  localparam int STATE_BIT = 10;
  localparam int PRIO_LSB = 16;
  localparam int PRIO_MSB = 20;
  localparam int LINK_LSB = 4;

  // Writable bits and reset values.
  localparam logic [31:0] ARITH_WMASK = 32'h0000_9107;
  localparam logic [31:0] PROCESS_WMASK = 32'h001F_0000;
  localparam logic [31:0] IP_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] FRAME_MASK = 32'hFFFF_FFC0;
  localparam logic [31:0] FRAME_BYTES = 32'h0000_0040;
  localparam logic [31:0] FRAME_LAST = 32'h0000_003F;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] TABLE_STRIDE_SHIFT = 32'h0000_0002;

  localparam logic [4:0] PRIO_MAX = 5'h1F;
  // Vector used for the unmaskable interrupt; the value is arbitrary.
  localparam logic [7:0] NMI_VECTOR = 8'hF8;

  // Call type codes kept in the low bits of the frame link local.
  localparam logic [2:0] CALL_LOCAL = 3'h0;
  localparam logic [2:0] CALL_FAULT = 3'h1;
  localparam logic [2:0] CALL_SUPER = 3'h2;
  localparam logic [2:0] CALL_INT = 3'h7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {
    MODE_PROGRAM = 1'b0,
    MODE_SERVICE = 1'b1
  } run_mode_t;

  typedef struct packed {
    logic valid;
    logic [4:0] priority_lvl;
    logic [7:0] vector;
  } irq_req_t;

  typedef struct packed {
    logic aw_rdy;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_rdy;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bus_state_t;

  typedef struct packed {
    bus_state_t bus;
    run_mode_t mode;
    logic [31:0] ip;
    logic [31:0] arith;
    logic [31:0] process;
    logic [31:0] saved_process;
    irq_req_t pend;
    logic [31:0] table_base;
    logic [31:0] frame_ptr;
    logic [31:0] frame_link;
    logic [31:0] stack_top;
    logic [31:0] return_addr;
    logic [15:0] busy;
    logic ovf_fault;
    logic int_accept;
    logic [31:0] handler_addr;
    logic pend_write;
    logic save_locals;
    logic [31:0] save_addr;
    logic issue_grant;
    logic ret_valid;
    logic [2:0] ret_type;
    logic [31:0] ret_ip;
  } core_state_t;

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ===== core_status_tb_top.sv
`timescale 1ns/100ps
module core_status_tb_top import core_status_pkg::*; ;
  logic core_clk, rst_n, awv, awr, wv, wrd, bv, brd, arv, arr, rv, rrd;
  logic ipl, ovf, ofl, pfo, nmi, iret, acc, pw, sf, isq, rtv, ig;
  logic cq, rq, sl, rvd;
  logic [7:0] awa, ara, pv, v;
  logic [31:0] wd, rd, ipv, cip, hadr, sa, return_address, ipo, ac, pc, fl, st, ra;
  logic [31:0] x, y, z, tbase;
  logic [3:0] ws, isd, isa, isb, rtd, d;
  logic [1:0] bresp, rresp, r;
  logic [4:0] pp, cp, p, q;
  logic [2:0] ct, rty;
  logic [15:0] busy, m, n;
  irq_req_t irq;
  logic [2:0] codes [4] = '{CALL_LOCAL, CALL_FAULT, CALL_SUPER, CALL_INT};
  int failures = 0;
  int check_count = 0;
  int cyc = 0;

  core_status i_core_status (
    .core_clk(core_clk), .rst_n(rst_n), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(brd),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv),
    .s_axi_rready(rrd), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .ip_load(ipl), .ip_value(ipv), .overflow_event(ovf),
    .overflow_fault(ofl), .precise_fault_only_bit(pfo), .nmi_req(nmi),
    .irq_in(irq), .int_return(iret), .int_accept(acc), .handler_addr(hadr),
    .pend_write(pw), .pend_priority(pp), .pend_vector(pv),
    .state_flag(sf), .cur_priority(cp), .issue_req(isq), .issue_dest(isd),
    .issue_src_a(isa), .issue_src_b(isb), .retire_valid(rtv),
    .retire_dest(rtd), .issue_grant(ig), .busy(busy), .call_req(cq),
    .call_type(ct), .call_next_ip(cip), .ret_req(rq), .save_locals(sl),
    .save_addr(sa), .ret_valid(rvd), .ret_type(rty), .ret_ip(return_address),
    .instruction_pointer(ipo), .arith_controls(ac),
    .process_controls(pc), .frame_link_local(fl), .stack_top_local(st),
    .return_address_local(ra)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    @(posedge core_clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= dt;
    brd <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    brd <= 1'b0;
    r = bresp;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge core_clk);
    arv <= 1'b1;
    ara <= a;
    rrd <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rrd <= 1'b0;
    x = rd;
    r = rresp;
  endtask

  // Lets the staged event inputs be sampled once, then drops them.
  task automatic go();
    @(posedge core_clk);
    {ipl, ovf, nmi, iret, isq, rtv, cq, rq} <= 8'h00;
    irq.valid <= 1'b0;
    #1;
  endtask

  task automatic sb(input logic iq, input logic [11:0] rg,
                    input logic [16:0] e);
    @(posedge core_clk);
    isq <= iq;
    rtv <= !iq;
    {isd, isa, isb} <= rg;
    rtd <= rg[11:8];
    go();
    chk(32'({ig, busy}), 32'(e));
  endtask

  initial begin
    {rst_n, awv, wv, brd, arv, rrd, ipl, ovf, nmi, iret} = '0;
    {isq, rtv, cq, rq, awa, ara, wd, ipv, cip, ct, irq} = '0;
    {isd, isa, isb, rtd} = 16'h0000;
    ws = 4'hF;
    void'($urandom(32'h6bd472c4));
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    rdr(OFS_ARITH);
    chk(x, RESET_WORD);
    rdr(OFS_PROCESS);
    chk(x, RESET_WORD);
    wr(OFS_ARITH, 32'hFFFF_FFFF);
    rdr(OFS_ARITH);
    chk(x, ARITH_WMASK);
    chk(32'(pfo), 32'h1);
    wr(8'h40, 32'h1);
    chk(32'(r), 32'(RESP_SLVERR));
    rdr(8'h40);
    chk(x | 32'(r), 32'(RESP_SLVERR));
    $display("register map test done");
    for (int i = 0; i < 4; i++) begin
      y = $urandom | 32'h3;
      @(posedge core_clk);
      ipl <= 1'b1;
      ipv <= y;
      go();
      chk(ipo, y & IP_MASK);
    end
    $display("instruction pointer test done");
    wr(OFS_ARITH, 32'h0000_1000);
    @(posedge core_clk);
    ovf <= 1'b1;
    go();
    chk(32'({ofl, ac[8]}), 32'h1);
    wr(OFS_ARITH, RESET_WORD);
    @(posedge core_clk);
    ovf <= 1'b1;
    go();
    chk(32'({ofl, ac[8], pfo}), 32'h4);
    $display("overflow test done");
    tbase = $urandom & 32'hFFFF_FF00;
    wr(OFS_TABLE_BASE, tbase);
    for (int i = 0; i < 24; i++) begin
      p = (i == 0 || i == 3) ? 5'h00 :
          (i < 3) ? 5'h1E + 5'(i - 1) : 5'($urandom);
      q = (i < 2) ? p : (i < 4) ? 5'h1F : 5'($urandom);
      v = 8'($urandom);
      wr(OFS_PROCESS, {11'h000, p, 16'h0000});
      chk(32'(cp), 32'(p));
      @(posedge core_clk);
      irq <= '{1'b1, q, v};
      go();
      if (q > p) begin
        chk(32'({acc, sf, cp}), 32'({2'b11, q}));
        chk(pc, {11'h000, q, 5'h00, 1'b1, 10'h000});
        chk(hadr, tbase + {22'h0, v, 2'b00});
        @(posedge core_clk);
        iret <= 1'b1;
        go();
        chk(32'({sf, cp}), 32'(p));
      end else begin
        chk(32'({pw, acc, pp, pv}), 32'({2'b10, q, v}));
        rdr(OFS_PENDING);
        chk(x, {16'h0000, v, 2'b00, q, 1'b1});
        wr(OFS_PENDING, 32'h1);
      end
    end
    $display("priority test done");
    wr(OFS_PROCESS, {11'h000, PRIO_MAX, 16'h0000});
    @(posedge core_clk);
    nmi <= 1'b1;
    irq <= '{1'b1, PRIO_MAX, 8'h11};
    go();
    chk(32'({acc, sf, cp, pw}), 32'hFF);
    chk(hadr, tbase + {22'h0, NMI_VECTOR, 2'b00});
    @(posedge core_clk);
    iret <= 1'b1;
    go();
    $display("unmaskable interrupt test done");
    for (int i = 0; i < 6; i++) begin
      d = 4'($urandom);
      m = 16'h1 << d;
      n = 16'h1 << (d + 4'h3);
      sb(1'b1, {d, d + 4'h1, d + 4'h2}, {1'b1, m});
      sb(1'b1, {d + 4'h3, d + 4'h4, d + 4'h5}, {1'b1, m | n});
      sb(1'b1, {d + 4'h6, d, d + 4'h7}, {1'b0, m | n});
      sb(1'b0, {d, 8'h00}, {1'b0, n});
      sb(1'b0, {d + 4'h3, 8'h00}, 17'h0);
    end
    $display("scoreboard test done");
    foreach (codes[k]) begin
      y = $urandom & 32'h0FFF_FFC0;
      z = $urandom;
      wr(OFS_FRAME_PTR, y);
      wr(OFS_STACK_TOP, y + 32'h24);
      @(posedge core_clk);
      cq <= 1'b1;
      ct <= codes[k];
      cip <= z;
      go();
      chk(fl, y | 32'(codes[k]));
      chk(ra, z & IP_MASK);
      chk(st, y + FRAME_BYTES + FRAME_LAST);
      chk({sa[31:1], sl}, y | 32'h1);
      @(posedge core_clk);
      rq <= 1'b1;
      go();
      chk(32'({rvd, rty}), 32'({1'b1, codes[k]}));
      chk(return_address, z & IP_MASK);
      chk(st, y + FRAME_LAST);
    end
    $display("call and return test done");
    give_verdict();
  end
endmodule

// ===== int_arbiter.sv
`timescale 1ns/100ps
module int_arbiter import core_status_pkg::*; (
  // Requests.
  input wire logic nmi,
  input wire irq_req_t irq,
  // Current task priority.
  input wire logic [4:0] cur_priority,
  // Decision.
  output logic take,
  output logic defer,
  output logic [4:0] new_priority,
  output logic [7:0] new_vector
);

  logic higher;

  always_comb begin
    higher = irq.priority_lvl > cur_priority;  // see [R9]
    take = nmi | (irq.valid & higher);  // see [R6]
    defer = irq.valid & (nmi | ~higher);  // see [R7]
    new_priority = nmi ? PRIO_MAX : irq.priority_lvl;
    new_vector = nmi ? NMI_VECTOR : irq.vector;
  end

endmodule
